// *** logic/thermal_array_map.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - Core results are stored at fixed locations.
// - Location 0 holds ambient in tenths degree.
// - Negative temperature stored as 65535 minus magnitude.
// - Location 65 holds raw reference sensor value.
// - Locations 66-97 hold raw pixel values.
// - Config bytes 0,1 hold writable sensor identifier.
// - Bytes 4,5 hold 7-bit slave address, default 0A.
// - Device type third bit enables ambient compensation.
// - Bytes 12,13 hold averaging count, default 13.
// - Result memory read only; config bytes 0,1,5,8,9,12,13 read and write, byte 4 read only, other bytes refused.
module thermal_array_map #(
    parameter logic [15:0] ID_DEFAULT = 16'h0000,
    parameter logic [15:0] DEV_TYPE_DEFAULT = 16'h0004
) (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Measurement core results
    input wire thermal_map_pkg::result_upd_t upd,
    // Deframed bus master requests
    input wire thermal_map_pkg::host_req_t host_req,
    // Answers to the bus master
    output logic rsp_valid,
    output logic rsp_refused,
    output logic [15:0] rsp_data,
    // Configuration seen by the measurement core
    output logic [15:0] sensor_id,
    output logic [6:0] slave_address,
    output logic amb_comp_enable,
    output logic [15:0] averaging_count
);

    // ----------------------------------------------------------------
    // Result update decode
    // ----------------------------------------------------------------
    logic [15:0] result_mem [0:thermal_map_pkg::RAM_WORDS-1];
    logic [7:0] cfg_mem [0:thermal_map_pkg::CFG_BYTES-1];

    wire logic [15:0] upd_loc = {9'h000, upd.addr};
    wire logic upd_is_temp =
        upd_loc <= thermal_map_pkg::OBJ_LAST_LOC;
    wire logic upd_is_raw = upd_loc >= thermal_map_pkg::REF_RAW_LOC
        && upd_loc <= thermal_map_pkg::PIX_RAW_LAST_LOC;
    wire logic upd_ok = upd.valid && (upd_is_temp || upd_is_raw);
    wire logic [15:0] upd_mag = upd.data[15]
        ? 16'(~upd.data + 16'h0001) : upd.data;
    // Temperatures arrive signed; raw values pass untouched.
    wire logic [15:0] upd_enc = (upd_is_temp && upd.data[15])
        ? thermal_map_pkg::TEMP_WRAP_MAX - upd_mag
        : upd.data;

    // ----------------------------------------------------------------
    // Bus master request decode
    // ----------------------------------------------------------------
    wire logic [15:0] addr = host_req.addr;
    wire logic [3:0] cfg_idx = addr[3:0];
    wire logic [6:0] ram_idx = addr[6:0];
    wire logic ram_hit = addr <= thermal_map_pkg::OBJ_LAST_LOC
        || (addr >= thermal_map_pkg::REF_RAW_LOC
        && addr <= thermal_map_pkg::PIX_RAW_LAST_LOC);
    wire logic cfg_in_range = addr < 16'(thermal_map_pkg::CFG_BYTES);
    wire logic cfg_rd_ok = cfg_in_range
        && thermal_map_pkg::CFG_READ_MASK[cfg_idx];
    wire logic cfg_wr_ok = cfg_in_range
        && thermal_map_pkg::CFG_WRITE_MASK[cfg_idx];
    // Writes into result memory are never accepted.
    wire logic req_refused = host_req.is_cfg
        ? (host_req.write ? !cfg_wr_ok : !cfg_rd_ok)
        : (host_req.write || !ram_hit);
    wire logic cfg_we = host_req.valid && host_req.is_cfg
        && host_req.write && cfg_wr_ok;
    wire logic [7:0] cfg_wbyte = (addr == thermal_map_pkg::SA_LSB_ADDR)
        ? (host_req.wdata & thermal_map_pkg::SA_FIELD_MASK)
        : host_req.wdata;
    wire logic [15:0] rd_word = host_req.is_cfg
        ? {8'h00, cfg_mem[cfg_idx]}
        : result_mem[ram_idx];
    wire logic [15:0] next_rsp_data = req_refused ? 16'h0000 : rd_word;

    // ----------------------------------------------------------------
    // Result memory
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < thermal_map_pkg::RAM_WORDS; i++) begin
                result_mem[i] <= 16'h0000;
            end
        end else if (upd_ok) begin
            result_mem[upd.addr] <= upd_enc;
        end
    end

    // ----------------------------------------------------------------
    // Configuration store
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < thermal_map_pkg::CFG_BYTES; i++) begin
                cfg_mem[i] <= 8'h00;
            end
            cfg_mem[0] <= ID_DEFAULT[15:8];
            cfg_mem[1] <= ID_DEFAULT[7:0];
            cfg_mem[5] <= thermal_map_pkg::SA_DEFAULT;
            cfg_mem[8] <= DEV_TYPE_DEFAULT[15:8];
            cfg_mem[9] <= DEV_TYPE_DEFAULT[7:0];
            cfg_mem[12] <= thermal_map_pkg::AVG_DEFAULT[15:8];
            cfg_mem[13] <= thermal_map_pkg::AVG_DEFAULT[7:0];
        end else if (cfg_we) begin
            cfg_mem[cfg_idx] <= cfg_wbyte;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rsp_valid <= 1'b0;
            rsp_refused <= 1'b0;
            rsp_data <= 16'h0000;
        end else begin
            rsp_valid <= host_req.valid;
            rsp_refused <= host_req.valid && req_refused;
            rsp_data <= host_req.valid ? next_rsp_data : 16'h0000;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sensor_id <= ID_DEFAULT;
            slave_address <= thermal_map_pkg::SA_DEFAULT[6:0];
            amb_comp_enable <= DEV_TYPE_DEFAULT[thermal_map_pkg::AMB_COMP_BIT];
            averaging_count <= thermal_map_pkg::AVG_DEFAULT;
        end else begin
            sensor_id <= {cfg_mem[0], cfg_mem[1]};
            slave_address <= cfg_mem[5][6:0];
            amb_comp_enable <=
                cfg_mem[9][thermal_map_pkg::AMB_COMP_BIT];
            averaging_count <= {cfg_mem[12], cfg_mem[13]};
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence cfg_write_at(logic [15:0] a);
        host_req.valid && host_req.is_cfg && host_req.write
            && host_req.addr == a;
    endsequence

    sequence cfg_read_at(logic [15:0] a);
        host_req.valid && host_req.is_cfg && !host_req.write
            && host_req.addr == a;
    endsequence

    chk_rsp_follows_req: assert property (
        @(posedge clock) disable iff (!nrst)
        host_req.valid |=> rsp_valid ##1 (rsp_valid == $past(host_req.valid)))
        else $error("answer did not follow request");

    chk_ram_write_refused: assert property (
        @(posedge clock) disable iff (!nrst)
        (host_req.valid && !host_req.is_cfg && host_req.write)
            |=> rsp_refused && rsp_data == 16'h0000)
        else $error("result memory write not refused");

    chk_sa_high_zero: assert property (
        @(posedge clock) disable iff (!nrst)
        cfg_read_at(thermal_map_pkg::SA_MSB_ADDR)
            |=> !rsp_refused && rsp_data == 16'h0000)
        else $error("slave address high byte not zero");

    chk_sa_write: assert property (
        @(posedge clock) disable iff (!nrst)
        cfg_write_at(thermal_map_pkg::SA_LSB_ADDR)
            |=> ##1 slave_address == $past(host_req.wdata[6:0], 2))
        else $error("slave address write lost");

    chk_id_write: assert property (
        @(posedge clock) disable iff (!nrst)
        cfg_write_at(thermal_map_pkg::ID_LSB_ADDR)
            |=> ##1 sensor_id[7:0] == $past(host_req.wdata, 2))
        else $error("sensor identifier write lost");

    chk_comp_flag: assert property (
        @(posedge clock) disable iff (!nrst)
        cfg_write_at(thermal_map_pkg::DEV_LSB_ADDR)
            |=> ##1 amb_comp_enable == $past(host_req.wdata[2], 2))
        else $error("compensation switch not updated");

    chk_avg_write: assert property (
        @(posedge clock) disable iff (!nrst)
        cfg_write_at(thermal_map_pkg::AVG_LSB_ADDR)
            |=> ##1 averaging_count[7:0] == $past(host_req.wdata, 2))
        else $error("averaging count write lost");

    chk_temp_encode: assert property (
        @(posedge clock) disable iff (!nrst)
        (upd.valid && upd.addr == 7'h00 && upd.data[15])
            |=> result_mem[0] == 16'($past(upd.data) - 16'h0001))
        else $error("negative ambient wrongly encoded");

    chk_obj_stored: assert property (
        @(posedge clock) disable iff (!nrst)
        (upd.valid && upd.addr == 7'h20 && !upd.data[15])
            |=> result_mem[32] == $past(upd.data))
        else $error("object temperature not stored");

    chk_raw_stored: assert property (
        @(posedge clock) disable iff (!nrst)
        (upd.valid && upd.addr >= 7'h41 && upd.addr <= 7'h61)
            |=> result_mem[$past(upd.addr)] == $past(upd.data))
        else $error("raw value altered on store");

    chk_ram_read: assert property (
        @(posedge clock) disable iff (!nrst)
        (host_req.valid && !host_req.is_cfg && !host_req.write
            && host_req.addr == thermal_map_pkg::REF_RAW_LOC && !upd.valid)
            |=> rsp_data == result_mem[65] && !rsp_refused)
        else $error("reference raw read wrong");

endmodule

// *** logic/thermal_map_pkg.sv ***
package thermal_map_pkg;

    // Result memory layout (word locations).
    localparam int RAM_WORDS = 98;
    localparam logic [15:0] AMBIENT_LOC = 16'h0000;
    localparam logic [15:0] OBJ_FIRST_LOC = 16'h0001;
    localparam logic [15:0] OBJ_LAST_LOC = 16'h0020;
    localparam logic [15:0] REF_RAW_LOC = 16'h0041;
    localparam logic [15:0] PIX_RAW_FIRST_LOC = 16'h0042;
    localparam logic [15:0] PIX_RAW_LAST_LOC = 16'h0061;
    localparam logic [15:0] TEMP_WRAP_MAX = 16'hFFFF;

    // Configuration store layout (byte addresses, MSB first).
    localparam int CFG_BYTES = 14;
    localparam logic [15:0] ID_MSB_ADDR = 16'h0000;
    localparam logic [15:0] ID_LSB_ADDR = 16'h0001;
    localparam logic [15:0] SA_MSB_ADDR = 16'h0004;
    localparam logic [15:0] SA_LSB_ADDR = 16'h0005;
    localparam logic [15:0] DEV_MSB_ADDR = 16'h0008;
    localparam logic [15:0] DEV_LSB_ADDR = 16'h0009;
    localparam logic [15:0] AVG_MSB_ADDR = 16'h000C;
    localparam logic [15:0] AVG_LSB_ADDR = 16'h000D;
    localparam logic [15:0] CFG_READ_MASK = 16'h3333;
    localparam logic [15:0] CFG_WRITE_MASK = 16'h3323;
    localparam logic [7:0] SA_FIELD_MASK = 8'h7F;
    localparam int AMB_COMP_BIT = 2;

    // Reset values.
    localparam logic [7:0] SA_DEFAULT = 8'h0A;
    localparam logic [15:0] AVG_DEFAULT = 16'h000D;

    // Request from the serial front end, already deframed.
    typedef struct packed {
        logic valid;
        logic is_cfg;
        logic write;
        logic [15:0] addr;
        logic [7:0] wdata;
    } host_req_t;

    // New result from the measurement core.
    typedef struct packed {
        logic valid;
        logic [6:0] addr;
        logic [15:0] data;
    } result_upd_t;

endpackage

// *** testbench/host_master.sv ***
`timescale 1ns/1ps
module host_master (
    // Clock
    input wire logic clock,
    // Request to the map
    output thermal_map_pkg::host_req_t req
);
    initial begin
        req = '0;
    end
    // One request a call, launched just after an edge.
    task automatic xfer(input logic c, input logic w,
            input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        #1;
        req.valid = 1'b1;
        req.is_cfg = c;
        req.write = w;
        req.addr = (c && w) ? {8'h00, a[7:0]} : a;
        req.wdata = w ? d : 8'h00;
        @(posedge clock);
        #1;
        // A released bus must not keep showing the last value.
        req.valid = 1'b0;
        req.addr = ~req.addr;
        req.wdata = ~req.wdata;
    endtask
endmodule

// *** testbench/thermal_array_map_bench.sv ***
`timescale 1ns/1ps
module thermal_array_map_bench;
    logic clock;
    logic nrst;
    thermal_map_pkg::result_upd_t upd;
    thermal_map_pkg::host_req_t host_req;
    logic rsp_valid;
    logic rsp_refused;
    logic [15:0] rsp_data;
    logic [15:0] sensor_id;
    logic [6:0] slave_address;
    logic amb_comp_enable;
    logic [15:0] averaging_count;
    int err_count = 0;
    int num_checks = 0;
    int cyc = 0;

    thermal_array_map u_dut (.clock(clock), .nrst(nrst), .upd(upd),
        .host_req(host_req), .rsp_valid(rsp_valid),
        .rsp_refused(rsp_refused), .rsp_data(rsp_data),
        .sensor_id(sensor_id), .slave_address(slave_address),
        .amb_comp_enable(amb_comp_enable),
        .averaging_count(averaging_count));
    host_master u_host (.clock(clock), .req(host_req));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic end_sim;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cyc++;
        if (cyc == 2000) begin
            err_count++;
            end_sim;
        end
    end

    task automatic chk(string n, logic [17:0] e, logic [17:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    // Accepted write answers carry no data worth comparing.
    task automatic acc(logic c, logic w, logic [15:0] a, logic [7:0] d,
            logic rf, logic [15:0] e);
        u_host.xfer(c, w, a, d);
        chk("rsp", {1'b1, rf, (w && !rf) ? rsp_data : e},
            {rsp_valid, rsp_refused, rsp_data});
    endtask

    task automatic put(logic [6:0] a, logic [15:0] d);
        @(posedge clock);
        #1;
        upd = {1'b1, a, d};
        @(posedge clock);
        #1;
        upd.valid = 1'b0;
    endtask

    task automatic settle;
        @(posedge clock);
        #1;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        nrst = 1'b0;
        upd = '0;
        repeat (12) @(posedge clock);
        #1;
        nrst = 1'b1;
        chk("sensor_id", 18'h0, sensor_id);
        chk("slave_address", 18'h0A, slave_address);
        chk("amb_comp", 18'h1, amb_comp_enable);
        chk("averaging_count", 18'hD, averaging_count);
        acc(1, 0, 16'h0004, 8'h00, 0, 16'h0000);
        acc(1, 0, 16'h0005, 8'h00, 0, 16'h000A);
        acc(1, 0, 16'h0009, 8'h00, 0, 16'h0004);
        acc(1, 0, 16'h000D, 8'h00, 0, 16'h000D);
        acc(1, 0, 16'h000E, 8'h00, 1, 16'h0000);
        acc(1, 0, 16'h0002, 8'h00, 1, 16'h0000);
        acc(1, 1, 16'h000E, 8'h77, 1, 16'h0000);
        acc(1, 1, 16'h0004, 8'h55, 1, 16'h0000);
        acc(1, 1, 16'h0005, 8'hFF, 0, 16'h0000);
        acc(1, 0, 16'h0005, 8'h00, 0, 16'h007F);
        chk("slave_address", 18'h7F, slave_address);
        acc(1, 1, 16'h0009, 8'h00, 0, 16'h0000);
        settle;
        chk("amb_comp", 18'h0, amb_comp_enable);
        acc(1, 1, 16'h000D, 8'h01, 0, 16'h0000);
        settle;
        chk("averaging_count", 18'h1, averaging_count);
        acc(1, 1, 16'h0000, 8'hA5, 0, 16'h0000);
        acc(1, 1, 16'h0001, 8'h3C, 0, 16'h0000);
        settle;
        chk("sensor_id", 18'hA53C, sensor_id);
        put(7'h00, 16'hFFCE);
        acc(0, 0, 16'h0000, 8'h00, 0, 16'hFFCD);
        put(7'h20, 16'h00FA);
        acc(0, 0, 16'h0020, 8'h00, 0, 16'h00FA);
        put(7'h41, 16'h1234);
        acc(0, 0, 16'h0041, 8'h00, 0, 16'h1234);
        put(7'h61, 16'hBEEF);
        acc(0, 0, 16'h0061, 8'h00, 0, 16'hBEEF);
        put(7'h21, 16'h1111);
        acc(0, 0, 16'h0021, 8'h00, 1, 16'h0000);
        acc(0, 0, 16'h0062, 8'h00, 1, 16'h0000);
        acc(0, 1, 16'h0000, 8'h11, 1, 16'h0000);
        acc(0, 0, 16'h0000, 8'h00, 0, 16'hFFCD);
        // A second reset reloads the configuration and clears results.
        settle;
        nrst = 1'b0;
        settle;
        nrst = 1'b1;
        chk("sensor_id", 18'h0, sensor_id);
        chk("averaging_count", 18'hD, averaging_count);
        acc(0, 0, 16'h0000, 8'h00, 0, 16'h0000);
        end_sim;
    end
endmodule
